// ==== bench/wcb_bus_model.sv ====
`timescale 1ns/1ns
module wcb_bus_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire logic slow,
	output logic cmd_ready
);
	logic [1:0] wait_reg;

	// take each command once; when slow, stall it for four cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_ready <= 1'b0;
			wait_reg <= 2'h0;
		end else if (cmd_valid && !cmd_ready) begin
			wait_reg <= wait_reg + 2'h1;
			cmd_ready <= !slow || wait_reg == 2'h3;
		end else begin
			cmd_ready <= 1'b0;
			wait_reg <= 2'h0;
		end
	end
endmodule

// ==== bench/wcb_top_chk.sv ====
`timescale 1ns/1ns
module wcb_top_chk
	import wcb_pkg::*;
#(
	parameter int WT_TIMEOUT = 16
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic st_valid,
	input wire wcb_store_t st,
	input wire logic st_ready,
	input wire wcb_close_evt_t close_evt,
	input wire wcb_read_t rd,
	input wire logic cmd_valid,
	input wire wcb_cmd_t cmd,
	input wire logic [511:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic buf_open
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	cmd_hold_a: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
		else $error("command changed before acceptance");
	cmd_gap_a: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
		else $error("no idle cycle after a command");
	drain_shut_a: assert property (
		cmd_valid |-> !st_ready && !buf_open)
		else $error("store taken or buffer open while draining");
	io_close_a: assert property (
		buf_open && (close_evt.io_access || close_evt.serialize) |=> !buf_open)
		else $error("port access or serializing left buffer open");
	flush_close_a: assert property (
		buf_open && (close_evt.flush || close_evt.lock_start
		|| close_evt.tlb_ad_set) |=> !buf_open)
		else $error("flush, lock or table update left buffer open");
	ucrd_close_a: assert property (
		buf_open && rd.valid && rd.mtype == uncacheable_memory_type
		|=> !buf_open) else $error("uncacheable read left buffer open");
	uc_alone_a: assert property (
		st_valid && st_ready && st.mtype == uncacheable_memory_type
		|=> !buf_open) else $error("uncacheable store left open");
	close_drain_a: assert property (
		$fell(buf_open) |-> ##[1:12] cmd_valid)
		else $error("closed buffer not sent");
	mask_set_a: assert property (cmd_valid |-> cmd.mask != 8'h00)
		else $error("command with empty mask");
endmodule

// ==== bench/wcb_top_tb.sv ====
`timescale 1ns/1ns
module wcb_top_tb;
	import wcb_pkg::*;
	logic clk = 0, arst_n = 0, st_valid = 0, slow = 0;
	logic st_ready, buf_open, cmd_valid, cmd_ready;
	wcb_store_t st = '0;
	wcb_close_evt_t close_evt = '0;
	wcb_read_t rd = '0;
	wcb_cmd_t cmd;
	logic [511:0] cmd_data;
	wcb_cmd_t q[$];
	logic [511:0] dq[$];
	logic [511:0] last_data = '0;
	int errors = 0, compares = 0;

	wcb_top #(.WT_TIMEOUT(4)) dut (.clk(clk), .arst_n(arst_n),
		.st_valid(st_valid), .st(st), .st_ready(st_ready),
		.close_evt(close_evt), .rd(rd), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .buf_open(buf_open));
	wcb_bus_model bus (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.slow(slow), .cmd_ready(cmd_ready));

	initial forever #5 clk = ~clk;
	// log every command at the edge the bus takes it
	always @(posedge clk) begin
		if (cmd_valid && cmd_ready) begin
			q.push_back(cmd);
			dq.push_back(cmd_data);
		end
	end

	task automatic conclude();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic miss(string s);
		errors++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	// hold the store until taken; a refused store waits up to 200 clocks, then the test ends
	task automatic put(logic [31:0] a, wcb_size_t z, wcb_mtype_t t);
		int n = 0;
		@(posedge clk);
		st_valid <= 1;
		st <= '{addr: a, size: z, data: {2{a}}, mtype: t};
		do @(negedge clk); while (st_ready !== 1'b1 && ++n < 200);
		if (n >= 200) begin
			miss("store never taken");
			conclude();
		end
		@(posedge clk);
		st_valid <= 0;
	endtask
	task automatic pulse(wcb_close_evt_t e, wcb_read_t r);
		@(posedge clk);
		close_evt <= e;
		rd <= r;
		@(posedge clk);
		close_evt <= '0;
		rd <= '0;
	endtask
	task automatic ex(wcb_cmd_kind_t k, logic [31:0] a, logic [7:0] m);
		wcb_cmd_t c;
		int n = 0;
		while (q.size() == 0 && n++ < 200) @(negedge clk);
		if (q.size() == 0) begin
			miss("no command");
			conclude();
		end
		c = q.pop_front();
		last_data = dq.pop_front();
		compares++;
		if (c !== wcb_cmd_t'{k, a, m}) miss("wrong command");
	endtask
	// one byte of the line carried by the command last taken
	task automatic chk_data(int b, logic [7:0] v);
		compares++;
		if (last_data[8*b +: 8] !== v) miss("wrong line data");
	endtask
	task automatic chk_open(logic e);
		@(negedge clk);
		compares++;
		if (buf_open !== e) miss("buffer state");
	endtask

	task automatic sc_comb();
		put(32'h108, wcb_sz_quad, combining_memory_type);
		put(32'h100, wcb_sz_quad, combining_memory_type);
		repeat (30) @(negedge clk);
		chk_open(1);
		pulse('{flush: 1, default: 0}, '0);
		ex(wcb_cmd_quad, 32'h100, 8'h03);
	endtask
	task automatic sc_full();
		for (int i = 0; i < 8; i++)
			put(32'h200 + 8 * i, wcb_sz_quad, combining_memory_type);
		ex(wcb_cmd_quad, 32'h200, 8'hFF);
	endtask
	task automatic sc_long();
		slow <= 1;
		put(32'h300, wcb_sz_long, combining_memory_type);
		put(32'h324, wcb_sz_long, combining_memory_type);
		pulse('{serialize: 1, default: 0}, '0);
		ex(wcb_cmd_long, 32'h300, 8'h01);
		ex(wcb_cmd_long, 32'h320, 8'h02);
		slow <= 0;
	endtask
	task automatic sc_walk();
		put(32'h405, wcb_sz_byte, combining_memory_type);
		put(32'h410, wcb_sz_quad, combining_memory_type);
		put(32'h41C, wcb_sz_long, combining_memory_type);
		pulse('{io_access: 1, default: 0}, '0);
		ex(wcb_cmd_byte, 32'h400, 8'h20);
		ex(wcb_cmd_quad, 32'h410, 8'h01);
		ex(wcb_cmd_long, 32'h418, 8'h02);
	endtask
	task automatic sc_lock();
		put(32'h900, wcb_sz_quad, combining_memory_type);
		pulse('{lock_start: 1, default: 0}, '0);
		ex(wcb_cmd_quad, 32'h900, 8'h01);
		put(32'h940, wcb_sz_quad, combining_memory_type);
		put(32'h948, wcb_sz_quad, combining_memory_type);
		pulse('{tlb_ad_set: 1, default: 0}, '0);
		ex(wcb_cmd_quad, 32'h940, 8'h03);
	endtask
	task automatic sc_wt();
		put(32'h503, wcb_sz_byte, writethrough_memory_type);
		put(32'h504, wcb_sz_word, writethrough_memory_type);
		put(32'h502, wcb_sz_byte, writethrough_memory_type);
		ex(wcb_cmd_byte, 32'h500, 8'h38);
		ex(wcb_cmd_byte, 32'h500, 8'h04);
		put(32'h604, wcb_sz_long, writethrough_memory_type);
		ex(wcb_cmd_long, 32'h600, 8'h02);
	endtask
	task automatic sc_close();
		put(32'h700, wcb_sz_quad, combining_memory_type);
		put(32'h740, wcb_sz_quad, combining_memory_type);
		ex(wcb_cmd_quad, 32'h700, 8'h01);
		put(32'h748, wcb_sz_byte, writeback_memory_type);
		chk_open(1);
		pulse('0, '{valid: 1, addr: 0, mtype: uncacheable_memory_type});
		ex(wcb_cmd_quad, 32'h740, 8'h01);
		put(32'h800, wcb_sz_long, uncacheable_memory_type);
		ex(wcb_cmd_long, 32'h800, 8'h01);
		put(32'h840, wcb_sz_quad, combining_memory_type);
		put(32'h848, wcb_sz_byte, writethrough_memory_type);
		ex(wcb_cmd_quad, 32'h840, 8'h01);
		ex(wcb_cmd_byte, 32'h848, 8'h01);
	endtask
	// writethrough store crossing a quadword: lower part closes
	task automatic sc_split();
		put(32'hA06, wcb_sz_long, writethrough_memory_type);
		ex(wcb_cmd_byte, 32'hA00, 8'hC0);
		chk_data(6, 8'h06);
		chk_data(7, 8'h0A);
		ex(wcb_cmd_byte, 32'hA08, 8'h03);
		chk_data(7, 8'h0A);
	endtask
	// combining read closes only on a line match
	task automatic sc_rdmatch();
		put(32'hB00, wcb_sz_quad, combining_memory_type);
		pulse('0, '{valid: 1, addr: 32'hC00,
			mtype: combining_memory_type});
		chk_open(1);
		pulse('0, '{valid: 1, addr: 32'hB10,
			mtype: combining_memory_type});
		ex(wcb_cmd_quad, 32'hB00, 8'h01);
		chk_data(0, 8'h00);
		chk_data(1, 8'h0B);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1;
		repeat (3) @(posedge clk);
		sc_comb();
		sc_full();
		sc_long();
		sc_walk();
		sc_lock();
		sc_wt();
		sc_close();
		sc_split();
		sc_rdmatch();
		conclude();
	end
endmodule

bind wcb_top wcb_top_chk #(.WT_TIMEOUT(WT_TIMEOUT)) chk (.clk(clk),
	.arst_n(arst_n), .st_valid(st_valid), .st(st), .st_ready(st_ready),
	.close_evt(close_evt), .rd(rd), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_data(cmd_data), .cmd_ready(cmd_ready), .buf_open(buf_open));

// ==== core/wcb_encoder.sv ====
`timescale 1ns/1ns
module wcb_encoder
	import wcb_pkg::*;
(
	input wire logic [63:0] byte_valid,
	input wire logic [2:0] step,
	output wcb_enc_t enc
);
	logic [7:0] qw_full;
	logic [7:0] qw_any;
	logic [15:0] lw_full;
	logic [15:0] lw_any;
	logic qw_uniform;
	logic lw_uniform;
	logic [7:0] qv;
	logic [7:0] lwm;

	// per-quadword and per-longword fill flags
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_qw
			assign qw_full[g] = &byte_valid[8*g +: 8];
			assign qw_any[g] = |byte_valid[8*g +: 8];
			assign lw_full[2*g] = &byte_valid[8*g +: 4];
			assign lw_any[2*g] = |byte_valid[8*g +: 4];
			assign lw_full[2*g+1] = &byte_valid[8*g+4 +: 4];
			assign lw_any[2*g+1] = |byte_valid[8*g+4 +: 4];
		end
	endgenerate

	assign qw_uniform = &(qw_full | ~qw_any);
	assign lw_uniform = &(lw_full | ~lw_any);
	assign qv = byte_valid[{step, 3'h0} +: 8];
	assign lwm = step[0] ? lw_full[15:8] : lw_full[7:0];

	// choose the encoding and produce the command for this step
	always_comb begin
		enc = '0;
		if (qw_uniform) begin
			enc.hit = (step == 3'h0);
			enc.last = 1'b1;
			enc.kind = wcb_cmd_quad;
			enc.mask = qw_full;
		end else if (lw_uniform) begin
			enc.hit = |lwm;
			enc.last = step[0];
			enc.kind = wcb_cmd_long;
			enc.offset = step[0] ? 6'h20 : 6'h00;
			enc.mask = lwm;
		end else begin
			enc.hit = |qv;
			enc.last = (step == 3'h7);
			enc.offset = {step, 3'h0};
			if (&qv) begin
				enc.kind = wcb_cmd_quad;
				enc.mask = 8'h01;
			end else if (qv == 8'h0F) begin
				enc.kind = wcb_cmd_long;
				enc.mask = 8'h01;
			end else if (qv == 8'hF0) begin
				enc.kind = wcb_cmd_long;
				enc.mask = 8'h02;
			end else begin
				enc.kind = wcb_cmd_byte;
				enc.mask = qv;
			end
		end
	end
endmodule

// ==== core/wcb_top.sv ====
// Behaviour
// - merge byte to quadword stores within aligned line
// - combining stores merge in any order
// - writethrough merges contiguous ascending within one quadword
// - writethrough closes on gap or byte seven
// - uncacheable and write-protected stores never merge
// - non-writeback store to other line closes
// - one open buffer; closed buffer takes nothing
// - port input or output closes merging
// - serializing instructions close merging
// - cache flush forces the buffer out
// - lock start closes; locked stores still merge
// - uncacheable read closes; combining read on match
// - switching combining and writethrough closes merging
// - all 64 bytes valid closes merging
// - writethrough closes after 16 idle clocks
// - split writethrough store: lower closes on byte seven, upper opens anew
// - accessed or dirty bit update closes merging
// - uniform quadwords give one quadword command
// - uniform longwords give one command per half holding a full longword
// - otherwise walk quadwords issuing per-quadword commands
`timescale 1ns/1ns
`include "wcb_regs.svh"
module wcb_top
	import wcb_pkg::*;
#(
	parameter int WT_TIMEOUT = `WCB_WT_TIMEOUT_CLKS
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic st_valid,
	input wire wcb_store_t st,
	output logic st_ready,
	input wire wcb_close_evt_t close_evt,
	input wire wcb_read_t rd,
	output logic cmd_valid,
	output wcb_cmd_t cmd,
	output logic [511:0] cmd_data,
	input wire logic cmd_ready,
	output logic buf_open
);
	generate
		if (WT_TIMEOUT < 1 || WT_TIMEOUT > 255) begin : g_chk
			$error("wcb_top: WT_TIMEOUT must be 1 to 255");
		end
	endgenerate

	typedef struct packed {
		wcb_state_t state;
		logic [63:0] valid;
		logic [511:0] data;
		logic [25:0] line;
		wcb_mtype_t mtype;
		logic [5:0] next_exp;
		logic [7:0] tmo;
		logic upper_part;
		logic [2:0] step;
		logic done;
		logic cmd_valid;
		wcb_cmd_t cmd;
	} wcb_core_t;

	localparam logic [7:0] TMO_LAST = 8'(WT_TIMEOUT - 1);

	logic [1:0] rst_sync_reg;
	logic rst_n;
	wcb_core_t s_reg;
	wcb_core_t s_next;
	wcb_enc_t enc;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	wcb_encoder u_enc (
		.byte_valid(s_reg.valid),
		.step(s_reg.step),
		.enc(enc)
	);

	// store lanes and data, positioned within a 16-byte window
	logic [3:0] nbytes;
	logic [15:0] lanes16;
	logic [127:0] data128;
	logic straddle;
	logic [31:0] part_addr;
	logic [7:0] part_lanes;
	logic [63:0] part_data;
	logic [25:0] pline;
	logic [5:0] poff;
	logic [3:0] pcount;

	always_comb begin
		nbytes = 4'h1 << st.size;
		lanes16 = 16'((16'h1 << nbytes) - 16'h1) << st.addr[2:0];
		data128 = 128'(st.data) << {st.addr[2:0], 3'h0};
		straddle = |lanes16[15:8];
		part_addr = st.addr;
		part_lanes = lanes16[7:0];
		part_data = data128[63:0];
		if (s_reg.upper_part) begin
			// second half of a store that crosses a quadword
			part_addr = {st.addr[31:3], 3'h0} + 32'h8;
			part_lanes = lanes16[15:8];
			part_data = data128[127:64];
		end
		pline = part_addr[31:6];
		poff = part_addr[5:0];
		pcount = 4'($countones(part_lanes));
	end

	// closing conditions
	logic is_open;
	logic is_wt;
	logic merge_type;
	logic ev_close;
	logic conflict;
	logic [63:0] new_valid;

	always_comb begin
		is_open = (s_reg.state == wcb_open);
		is_wt = (s_reg.mtype == writethrough_memory_type);
		merge_type = (st.mtype == combining_memory_type) ||
			(st.mtype == writethrough_memory_type);
		ev_close = close_evt.io_access
			| close_evt.serialize
			| close_evt.flush
			| close_evt.lock_start
			| close_evt.tlb_ad_set
			| (rd.valid && rd.mtype == uncacheable_memory_type)
			| (rd.valid && rd.mtype == combining_memory_type
				&& rd.addr[31:6] == s_reg.line);
		conflict = (pline != s_reg.line)
			|| (st.mtype != s_reg.mtype)
			|| !merge_type
			|| (is_wt && poff != s_reg.next_exp);
		new_valid = s_reg.valid
			| (64'(part_lanes) << {part_addr[5:3], 3'h0});
	end

	// next-state logic
	always_comb begin
		s_next = s_reg;
		st_ready = 1'b0;
		case (s_reg.state)
			wcb_empty, wcb_open: begin
				if (is_open && ev_close) begin
					s_next.state = wcb_drain;
				end else if (st_valid &&
					st.mtype == writeback_memory_type) begin
					st_ready = 1'b1;
				end else if (st_valid && is_open && conflict) begin
					s_next.state = wcb_drain;
				end else if (st_valid) begin
					// merge this part into the buffer
					s_next.valid = new_valid;
					for (int b = 0; b < 64; b++) begin
						if (b / 8 == int'(part_addr[5:3]) &&
							part_lanes[b % 8]) begin
							s_next.data[8*b +: 8] =
								part_data[8*(b % 8) +: 8];
						end
					end
					s_next.line = pline;
					s_next.mtype = st.mtype;
					s_next.next_exp = 6'(poff + 6'(pcount));
					s_next.tmo = `WCB_TMO_RST;
					s_next.state = wcb_open;
					if (straddle && !s_reg.upper_part) begin
						s_next.upper_part = 1'b1;
					end else begin
						s_next.upper_part = 1'b0;
						st_ready = 1'b1;
					end
					if (!merge_type) begin
						s_next.state = wcb_drain;
					end
					if (st.mtype == writethrough_memory_type &&
						part_lanes[`WCB_QW_LAST_BYTE]) begin
						s_next.state = wcb_drain;
					end
					if (&new_valid) begin
						s_next.state = wcb_drain;
					end
				end else if (is_open && is_wt) begin
					// idle writethrough merge ages out
					if (s_reg.tmo >= TMO_LAST) begin
						s_next.state = wcb_drain;
					end else begin
						s_next.tmo = s_reg.tmo + 8'h01;
					end
				end
				if (s_next.state == wcb_drain) begin
					s_next.step = `WCB_STEP_RST;
					s_next.done = 1'b0;
				end
			end
			wcb_drain: begin
				if (s_reg.cmd_valid) begin
					if (cmd_ready) begin
						s_next.cmd_valid = 1'b0;
					end
				end else if (s_reg.done) begin
					s_next.valid = `WCB_VALID_RST;
					s_next.tmo = `WCB_TMO_RST;
					s_next.state = wcb_empty;
				end else begin
					if (enc.hit) begin
						s_next.cmd_valid = 1'b1;
						s_next.cmd.kind = enc.kind;
						s_next.cmd.addr = {s_reg.line, enc.offset};
						s_next.cmd.mask = enc.mask;
					end
					if (enc.last) begin
						s_next.done = 1'b1;
					end else begin
						s_next.step = s_reg.step + 3'h1;
					end
				end
			end
			default: begin
				s_next.state = wcb_empty;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_valid = s_reg.cmd_valid;
	assign cmd = s_reg.cmd;
	assign cmd_data = s_reg.data;
	assign buf_open = (s_reg.state == wcb_open);
endmodule

// ==== inc/wcb_pkg.sv ====
package wcb_pkg;

	typedef enum logic [2:0] {
		writeback_memory_type,
		combining_memory_type,
		writethrough_memory_type,
		uncacheable_memory_type,
		writeprotect_memory_type
	} wcb_mtype_t;

	typedef enum logic [1:0] {
		wcb_sz_byte,
		wcb_sz_word,
		wcb_sz_long,
		wcb_sz_quad
	} wcb_size_t;

	typedef enum logic [1:0] {
		wcb_cmd_quad,
		wcb_cmd_long,
		wcb_cmd_byte
	} wcb_cmd_kind_t;

	typedef enum logic [1:0] {
		wcb_empty,
		wcb_open,
		wcb_drain
	} wcb_state_t;

	// one store from the load/store path
	typedef struct packed {
		logic [31:0] addr;
		wcb_size_t size;
		logic [63:0] data;
		wcb_mtype_t mtype;
	} wcb_store_t;

	// one-cycle events that close the open buffer
	typedef struct packed {
		logic io_access;
		logic serialize;
		logic flush;
		logic lock_start;
		logic tlb_ad_set;
	} wcb_close_evt_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		wcb_mtype_t mtype;
	} wcb_read_t;

	// masked write command toward the system bus
	typedef struct packed {
		wcb_cmd_kind_t kind;
		logic [31:0] addr;
		logic [7:0] mask;
	} wcb_cmd_t;

	// one step of the encoder walk
	typedef struct packed {
		logic hit;
		logic last;
		wcb_cmd_kind_t kind;
		logic [5:0] offset;
		logic [7:0] mask;
	} wcb_enc_t;

endpackage

// ==== inc/wcb_regs.svh ====
`ifndef WCB_REGS_SVH
`define WCB_REGS_SVH

// line geometry
`define WCB_LINE_BYTES 64
`define WCB_QW_BYTES 8
`define WCB_QW_LAST_BYTE 3'h7
// closing time for a writethrough merge, in processor clocks
`define WCB_WT_TIMEOUT_CLKS 16
// reset values
`define WCB_VALID_RST 64'h0
`define WCB_STEP_RST 3'h0
`define WCB_TMO_RST 8'h00

`endif
